// ==== core/cjasu_defs.vh ====
// constants for the conditional jump and add/subtract unit
`ifndef CJASU_DEFS_VH
`define CJASU_DEFS_VH
// opcodes (octal as printed)
`define CJASU_OP_QJUMP 6'o27
`define CJASU_OP_ADDIMM 6'o31
`define CJASU_OP_ADD 6'o32
`define CJASU_OP_ADDWB 6'o33
`define CJASU_OP_INCST 6'o34
`define CJASU_OP_LDSUMQ 6'o35
`define CJASU_OP_ADDQST 6'o36
`define CJASU_OP_STPQWB 6'o37
`define CJASU_OP_SUBIMM 6'o41
`define CJASU_OP_SUB 6'o42
`define CJASU_OP_SUBWB 6'o43
// word layout
`define CJASU_WORD_W 24
`define CJASU_SIGN_BIT 23
`define CJASU_ADDR_W 15
`define CJASU_RESET_WORD 24'h00_0000
// operation times in microseconds
`define CJASU_T_32US 8'h20
`define CJASU_T_12US 8'h0C
`define CJASU_T_40US 8'h28
`define CJASU_T_20US 8'h14
`define CJASU_T_56US 8'h38
`define CJASU_T_60US 8'h3C
`define CJASU_T_68US 8'h44
`define CJASU_T_48US 8'h30
`define CJASU_T_28US 8'h1C
`define CJASU_T_36US 8'h24
// clock cycles per microsecond at 200 MHz
`define CJASU_CLK_MHZ 16'h00C8
`endif

// ==== core/cjasu_ones_adder.v ====
// 24-bit one's-complement adder with end-around carry
`timescale 1ns/100ps
`include "cjasu_defs.vh"
module cjasu_ones_adder (
   input wire [23:0] opA, // first operand
   input wire [23:0] opB, // second operand
   input wire negB, // complement opB first
   output wire [23:0] sum // one's-complement sum
);
   wire [23:0] addend;
   wire [24:0] raw;
   // subtract by adding the complement, then fold carry back
   assign addend = negB ? ~opB : opB;
   assign raw = {1'b0, opA} + {1'b0, addend};
   assign sum = raw[23:0] + {23'h00_0000, raw[24]};
endmodule // cjasu_ones_adder

// ==== core/cjasu_portion.v ====
// word-portion selection for storage operands
`timescale 1ns/100ps
module cjasu_portion (
   input wire [2:0] modSel, // portion designator
   input wire [23:0] word, // full storage word
   input wire [23:0] oldWord, // word before write (merge base)
   input wire [23:0] newVal, // value to merge on write
   output reg [23:0] readVal, // selected portion, right-justified
   output reg [23:0] mergeVal // old word with portion replaced
);
   // 0 full, 1 lower half, 2 upper half, 3..5 thirds, 6..7 full
   always @* begin
      case (modSel)
         3'd1: begin
            readVal = {12'h000, word[11:0]};
            mergeVal = {oldWord[23:12], newVal[11:0]};
         end
         3'd2: begin
            readVal = {12'h000, word[23:12]};
            mergeVal = {newVal[11:0], oldWord[11:0]};
         end
         3'd3: begin
            readVal = {16'h0000, word[7:0]};
            mergeVal = {oldWord[23:8], newVal[7:0]};
         end
         3'd4: begin
            readVal = {16'h0000, word[15:8]};
            mergeVal = {oldWord[23:16], newVal[7:0], oldWord[7:0]};
         end
         3'd5: begin
            readVal = {16'h0000, word[23:16]};
            mergeVal = {newVal[7:0], oldWord[15:0]};
         end
         default: begin
            readVal = word;
            mergeVal = newVal;
         end
      endcase
   end
endmodule // cjasu_portion

// ==== core/cjasu_unit.v ====
// execution datapath for secondary jump and add/subtract instructions
`timescale 1ns/100ps
`include "cjasu_defs.vh"
module cjasu_unit (
   input wire clk, // 200 MHz clock
   input wire reset, // synchronous, active high
   input wire start, // one-cycle instruction start
   input wire [5:0] opcode, // decoded operation code
   input wire [2:0] modifier, // m field
   input wire [2:0] indexSel, // b field, zero means none
   input wire [14:0] addrField, // low 15 bits of instruction
   input wire [14:0] indexVal, // contents of selected index register
   input wire [14:0] progCount, // address of this instruction
   input wire repeatOn, // repeat control active
   input wire traceOn, // trace-jump control active
   input wire secLoad, // load secondary while idle
   input wire [23:0] secIn, // value for the secondary register
   input wire memAck, // storage cycle done, rdData valid
   input wire [23:0] rdData, // storage read data
   output reg memRd, // storage read request (level until ack)
   output reg memWr, // storage write request (level until ack)
   output reg [14:0] memAddr, // storage address
   output reg [23:0] wrData, // storage write data
   output reg busy, // instruction in progress
   output reg done, // one-cycle completion pulse
   output reg jumpTaken, // jump performed, valid with done
   output reg [14:0] nextAddr, // next instruction address, valid with done
   output reg repeatEnd, // repeat sequence ends, valid with done
   output reg [23:0] accOut, // accumulator
   output reg [23:0] secOut // secondary register
);
   // sequencer state codes
   localparam ST_IDLE = 3'd0;
   localparam ST_READ = 3'd1;
   localparam ST_CALC = 3'd2;
   localparam ST_WRITE = 3'd3;
   localparam ST_WAIT = 3'd4;
   localparam ST_DONE = 3'd5;
   localparam [15:0] CYC_US = `CJASU_CLK_MHZ;

   // instruction fields and working registers held for the whole operation
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [5:0] op_r;
   reg [2:0] mod_r;
   reg rep_r;
   reg trace_r;
   reg [14:0] addr_r;
   reg [14:0] pc_r;
   reg [23:0] opnd_r;
   reg [23:0] oldWord_r;
   reg [15:0] timer_r;
   reg [15:0] target_r;
   reg [23:0] acc_r;
   reg [23:0] sec_r;
   reg jmp_r;
   reg [14:0] next_r;

   // combinational helpers
   wire [14:0] effAddr;
   wire [23:0] portionVal;
   wire [23:0] mergedWord;
   reg [23:0] addA;
   reg [23:0] addB;
   reg negB;
   wire [23:0] sumVal;
   wire needRead;
   wire needWrite;
   wire jumpCond;
   reg [7:0] usTime;
   wire [23:0] linkWord;
   wire [23:0] secRotated;
   wire [23:0] wbWord;

   // operand address or immediate: low 15 bits plus index
   assign effAddr = (indexSel == 3'd0) ? addrField : addrField + indexVal;

   // storage operands read only portion selected by m
   cjasu_portion portion (
      .modSel(mod_r),
      .word(rdData),
      .oldWord(oldWord_r),
      .newVal(sumVal), // the fresh sum goes into the old word
      .readVal(portionVal),
      .mergeVal(mergedWord)
   );

   // one's-complement arithmetic, subtract by complement
   cjasu_ones_adder adder (
      .opA(addA),
      .opB(addB),
      .negB(negB),
      .sum(sumVal)
   );

   // opcodes that fetch a storage operand
   assign needRead = (op_r == `CJASU_OP_ADD) || (op_r == `CJASU_OP_ADDWB) ||
      (op_r == `CJASU_OP_INCST) || (op_r == `CJASU_OP_LDSUMQ) ||
      (op_r == `CJASU_OP_STPQWB) || (op_r == `CJASU_OP_SUB) ||
      (op_r == `CJASU_OP_SUBWB);
   // opcodes that end with a storage write
   assign needWrite = (op_r == `CJASU_OP_ADDWB) || (op_r == `CJASU_OP_INCST) ||
      (op_r == `CJASU_OP_ADDQST) || (op_r == `CJASU_OP_STPQWB) ||
      (op_r == `CJASU_OP_SUBWB);
   // sign test: even m positive, odd m negative
   assign jumpCond = mod_r[0] ? sec_r[`CJASU_SIGN_BIT] : ~sec_r[`CJASU_SIGN_BIT];

   // link word for a return jump: address after this instruction
   assign linkWord = {9'h000, pc_r + 15'h0001};

   // secondary rotated circularly left by one
   assign secRotated = {sec_r[22:0], sec_r[`CJASU_SIGN_BIT]};

   // write-back word: full result, or the result merged into the old word
   assign wbWord = (op_r == `CJASU_OP_ADDQST) ? sumVal :
      (mod_r == 3'd0 || mod_r[2:1] == 2'b11) ? sumVal :
      mergedWord;

   // adder operand selection per opcode
   always @* begin
      addA = acc_r;
      addB = opnd_r;
      negB = 1'b0;
      case (op_r)
         `CJASU_OP_ADDIMM, `CJASU_OP_ADD, `CJASU_OP_ADDWB: begin
            addB = opnd_r;
         end
         `CJASU_OP_INCST: begin
            addA = opnd_r;
            addB = 24'h00_0001;
         end
         `CJASU_OP_LDSUMQ, `CJASU_OP_STPQWB: begin
            addA = opnd_r;
            addB = sec_r;
         end
         `CJASU_OP_ADDQST: begin
            addB = sec_r;
         end
         `CJASU_OP_SUBIMM, `CJASU_OP_SUB, `CJASU_OP_SUBWB: begin
            negB = 1'b1;
         end
         default: begin
            negB = 1'b0;
         end
      endcase
   end

   // operation time in microseconds
   always @* begin
      case (op_r)
         `CJASU_OP_QJUMP: begin
            // a taken return or trace jump is the long case
            if (jmp_r && (trace_r || mod_r[2]))
               usTime = `CJASU_T_56US;
            else if (jmp_r || !rep_r)
               usTime = `CJASU_T_40US;
            else
               usTime = `CJASU_T_20US;
         end
         `CJASU_OP_ADDIMM: usTime = rep_r ? `CJASU_T_12US : `CJASU_T_32US;
         `CJASU_OP_SUBIMM: usTime = `CJASU_T_32US;
         `CJASU_OP_ADD, `CJASU_OP_SUB: usTime = rep_r ? `CJASU_T_20US : `CJASU_T_40US;
         `CJASU_OP_ADDWB, `CJASU_OP_INCST, `CJASU_OP_SUBWB:
            usTime = rep_r ? `CJASU_T_40US : `CJASU_T_60US;
         `CJASU_OP_STPQWB: usTime = rep_r ? `CJASU_T_48US : `CJASU_T_68US;
         `CJASU_OP_LDSUMQ: usTime = rep_r ? `CJASU_T_28US : `CJASU_T_48US;
         `CJASU_OP_ADDQST: usTime = rep_r ? `CJASU_T_36US : `CJASU_T_56US;
         default: usTime = `CJASU_T_32US;
      endcase
   end

   // sequencing of read, compute, write, timed wait
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (start) state_nxt = ST_READ;
         ST_READ: begin
            if (!needRead)
               state_nxt = ST_CALC;
            else if (memAck)
               state_nxt = ST_CALC;
         end
         ST_CALC: state_nxt = (needWrite || (op_r == `CJASU_OP_QJUMP && jmp_r &&
            (trace_r || mod_r[2]))) ? ST_WRITE : ST_WAIT;
         ST_WRITE: if (memAck) state_nxt = ST_WAIT;
         // hold until the operation time has run out
         ST_WAIT: if (timer_r >= target_r) state_nxt = ST_DONE;
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // datapath registers
   always @(posedge clk) begin
      if (reset) begin
         // all state and outputs clear on reset
         state_r <= ST_IDLE;
         op_r <= 6'h00;
         mod_r <= 3'h0;
         rep_r <= 1'b0;
         trace_r <= 1'b0;
         addr_r <= 15'h0000;
         pc_r <= 15'h0000;
         opnd_r <= `CJASU_RESET_WORD;
         oldWord_r <= `CJASU_RESET_WORD;
         timer_r <= 16'h0000;
         target_r <= 16'h0000;
         acc_r <= `CJASU_RESET_WORD;
         sec_r <= `CJASU_RESET_WORD;
         jmp_r <= 1'b0;
         next_r <= 15'h0000;
         memRd <= 1'b0;
         memWr <= 1'b0;
         memAddr <= 15'h0000;
         wrData <= `CJASU_RESET_WORD;
         busy <= 1'b0;
         done <= 1'b0;
         jumpTaken <= 1'b0;
         nextAddr <= 15'h0000;
         repeatEnd <= 1'b0;
         accOut <= `CJASU_RESET_WORD;
         secOut <= `CJASU_RESET_WORD;
      end else begin
         // sequencer advance and operation timer
         state_r <= state_nxt;
         done <= 1'b0;
         timer_r <= (state_r == ST_IDLE) ? 16'h0000 : timer_r + 16'h0001;
         case (state_r)
            // latch the instruction fields on start
            ST_IDLE: begin
               if (start) begin
                  op_r <= opcode;
                  // immediate ops ignore m, full word operand
                  mod_r <= (opcode == `CJASU_OP_ADDIMM || opcode == `CJASU_OP_SUBIMM) ?
                     3'd0 : modifier;
                  rep_r <= repeatOn;
                  trace_r <= traceOn;
                  addr_r <= effAddr;
                  pc_r <= progCount;
                  opnd_r <= {9'h000, effAddr}; // immediate is positive 15-bit
                  busy <= 1'b1;
                  jmp_r <= 1'b0;
                  memAddr <= effAddr;
                  memRd <= (opcode != `CJASU_OP_QJUMP && opcode != `CJASU_OP_ADDIMM &&
                     opcode != `CJASU_OP_SUBIMM && opcode != `CJASU_OP_ADDQST);
               end else if (secLoad) begin
                  // secondary filled from outside, shown at once on secOut
                  sec_r <= secIn;
                  secOut <= secIn;
               end
            end
            // take the storage operand when it arrives
            ST_READ: begin
               if (needRead && memAck) begin
                  memRd <= 1'b0;
                  opnd_r <= portionVal;
                  oldWord_r <= rdData;
               end
               if (op_r == `CJASU_OP_QJUMP)
                  jmp_r <= jumpCond;
            end
            // compute, set the timed target, prepare any storage write
            ST_CALC: begin
               target_r <= CYC_US * {8'h00, usTime};
               if (op_r == `CJASU_OP_QJUMP) begin
                  // rotate after the test, taken or not, unless m bit 1 is set
                  if (!mod_r[1])
                     sec_r <= secRotated;
                  if (!jmp_r) begin
                     // no jump: continue in sequence
                     next_r <= pc_r + 15'h0001;
                  end else if (trace_r) begin
                     // trace control: return jump to zero
                     memAddr <= 15'h0000;
                     wrData <= linkWord;
                     next_r <= 15'h0001;
                  end else if (mod_r[2]) begin
                     // return jump: link stored at target
                     memAddr <= addr_r;
                     wrData <= linkWord;
                     next_r <= addr_r + 15'h0001;
                  end else begin
                     next_r <= addr_r; // normal jump
                  end
                  memWr <= jmp_r && (trace_r || mod_r[2]);
               end else begin
                  acc_r <= sumVal;
                  next_r <= pc_r + 15'h0001;
                  memWr <= needWrite;
                  memAddr <= addr_r;
                  // write back only the designated portion, or the full word for ADDQST
                  wrData <= wbWord;
               end
            end
            // hold the write until storage acknowledges
            ST_WRITE: begin
               if (memAck) memWr <= 1'b0;
            end
            // completion pulse and result outputs
            ST_DONE: begin
               busy <= 1'b0;
               done <= 1'b1;
               jumpTaken <= jmp_r;
               nextAddr <= next_r;
               repeatEnd <= rep_r && jmp_r;
               accOut <= acc_r;
               secOut <= sec_r;
            end
            default: begin
               busy <= busy;
            end
         endcase
      end
   end
endmodule // cjasu_unit

// ==== test/cjasu_mem_model.sv ====
// core storage model answering after a set number of wait cycles
`timescale 1ns/100ps
module cjasu_mem_model (
   input wire clk, // clock
   input wire reset, // sync reset
   input wire memRd, // read request
   input wire memWr, // write request
   input wire [14:0] memAddr, // address
   input wire [23:0] wrData, // write data
   input wire [3:0] waitCyc, // wait cycles
   output reg memAck, // cycle done
   output reg [23:0] rdData // read data
);
   reg [23:0] mem [0:32767];
   reg [3:0] cnt_r;
   // idle data bus toggles so stale data never looks valid
   always @(posedge clk) begin
      memAck <= 1'b0;
      rdData <= ~rdData;
      if (reset) begin
         cnt_r <= 4'h0;
         rdData <= 24'h5A_5A5A;
      end else if ((memRd || memWr) && !memAck) begin
         if (cnt_r == waitCyc) begin
            cnt_r <= 4'h0;
            memAck <= 1'b1;
            if (memRd) rdData <= mem[memAddr];
            if (memWr) mem[memAddr] <= wrData;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule // cjasu_mem_model

// ==== test/cjasu_unit_checker.sv ====
// assertion checker for the jump and add/subtract unit
`timescale 1ns/100ps
`include "cjasu_defs.vh"
module cjasu_unit_checker (
   input wire clk, // clock
   input wire reset, // sync reset
   input wire start, // start pulse
   input wire busy, // in progress
   input wire done, // completion
   input wire [5:0] opcode, // operation
   input wire [2:0] modifier, // m field
   input wire [2:0] indexSel, // b field
   input wire [14:0] addrField, // low bits
   input wire [14:0] indexVal, // index value
   input wire repeatOn, // repeat level
   input wire traceOn, // trace level
   input wire memRd, // read request
   input wire memWr, // write request
   input wire [14:0] memAddr, // address
   input wire jumpTaken, // jump flag
   input wire [14:0] nextAddr, // next address
   input wire repeatEnd, // repeat end
   input wire [23:0] secOut // secondary
);
   reg [23:0] secAtStart_r;
   reg [15:0] cyc_r;
   // keep the secondary value seen at start and count cycles since start
   always @(posedge clk) begin
      if (reset) begin
         cyc_r <= 16'h0000;
         secAtStart_r <= 24'h00_0000;
      end else if (start && !busy) begin
         cyc_r <= 16'h0001;
         secAtStart_r <= secOut;
      end else begin
         cyc_r <= cyc_r + 16'h0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_jumpDone;
      done && opcode == `CJASU_OP_QJUMP;
   endsequence
   AST_JUMP_SENSE:
   assert property (s_jumpDone |-> jumpTaken == (modifier[0] == secAtStart_r[23]))
      else $error("jump decision wrong");
   AST_SEC_ROTATE:
   assert property (s_jumpDone |-> secOut == (modifier[1] ? secAtStart_r
      : {secAtStart_r[22:0], secAtStart_r[23]})) else $error("secondary rotate wrong");
   AST_REPEAT_END:
   assert property (done && repeatOn |-> repeatEnd == jumpTaken)
      else $error("repeat end wrong");
   AST_TRACE_ZERO:
   assert property (done && jumpTaken && traceOn |-> nextAddr == 15'h0001)
      else $error("trace jump target wrong");
   AST_IMM_NO_MEM:
   assert property (busy && (opcode == `CJASU_OP_ADDIMM || opcode == `CJASU_OP_SUBIMM)
      |-> !memRd && !memWr) else $error("immediate op touched storage");
   AST_READ_ADDR:
   assert property (memRd && opcode != `CJASU_OP_QJUMP |-> memAddr ==
      (indexSel != 3'h0 ? addrField + indexVal : addrField)) else $error("address wrong");
   AST_NO_WRITE:
   assert property (busy && (opcode == `CJASU_OP_ADD || opcode == `CJASU_OP_LDSUMQ
      || opcode == `CJASU_OP_SUB) |-> !memWr) else $error("unexpected write");
   AST_SUBIMM_TIME:
   assert property (done && opcode == `CJASU_OP_SUBIMM && !repeatOn
      |-> cyc_r >= 16'd6398 && cyc_r <= 16'd6460) else $error("immediate time wrong");
endmodule // cjasu_unit_checker
bind cjasu_unit cjasu_unit_checker cjasu_unit_checker_i (.clk(clk), .reset(reset),
   .start(start), .busy(busy), .done(done), .opcode(opcode), .modifier(modifier),
   .indexSel(indexSel), .addrField(addrField), .indexVal(indexVal), .repeatOn(repeatOn),
   .traceOn(traceOn), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
   .jumpTaken(jumpTaken), .nextAddr(nextAddr), .repeatEnd(repeatEnd), .secOut(secOut));

// ==== test/test_cjasu_unit.sv ====
// self-checking testbench for the jump and add/subtract unit
`timescale 1ns/100ps
`include "cjasu_defs.vh"
module test_cjasu_unit;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg start = 1'b0;
   reg [5:0] opcode = 6'h00;
   reg [2:0] modifier = 3'h0;
   reg [2:0] indexSel = 3'h2;
   reg [14:0] addrField = 15'h0000;
   reg [14:0] indexVal = 15'h0010;
   reg [14:0] progCount = 15'h0200;
   reg repeatOn = 1'b0;
   reg traceOn = 1'b0;
   reg secLoad = 1'b0;
   reg [23:0] secIn = 24'h00_0000;
   reg [3:0] waitCyc = 4'h0;
   wire memAck, memRd, memWr, busy, done, jumpTaken, repeatEnd;
   wire [23:0] rdData, wrData, accOut, secOut;
   wire [14:0] memAddr, nextAddr;
   integer errorCnt = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer lat = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   cjasu_unit cjasu_unit_i (.clk(clk), .reset(reset), .start(start), .opcode(opcode),
      .modifier(modifier), .indexSel(indexSel), .addrField(addrField),
      .indexVal(indexVal), .progCount(progCount), .repeatOn(repeatOn),
      .traceOn(traceOn), .secLoad(secLoad), .secIn(secIn), .memAck(memAck),
      .rdData(rdData), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
      .wrData(wrData), .busy(busy), .done(done),
      .jumpTaken(jumpTaken), .nextAddr(nextAddr), .repeatEnd(repeatEnd),
      .accOut(accOut), .secOut(secOut));
   cjasu_mem_model cjasu_mem_model_i (.clk(clk), .reset(reset), .memRd(memRd),
      .memWr(memWr), .memAddr(memAddr), .wrData(wrData), .waitCyc(waitCyc),
      .memAck(memAck), .rdData(rdData));
   task endOfTest;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
         if (errorCnt == 0 && comparisons > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task check(input [23:0] seen, input [23:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            errorCnt = errorCnt + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // true when the measured time is the given microseconds plus a little
   function ok(input integer t);
      ok = (lat >= 200 * t - 2) && (lat <= 200 * t + 60);
   endfunction
   // one instruction: start pulse, then wait for done under a bound
   task run(input [5:0] op, input [2:0] m, input [14:0] a, input rep, input trc);
      begin
         @(negedge clk);
         opcode = op;
         modifier = m;
         addrField = a;
         repeatOn = rep;
         traceOn = trc;
         start = 1'b1;
         @(negedge clk);
         start = 1'b0;
         lat = 1;
         while (done !== 1'b1 && lat < 20000) begin
            @(negedge clk);
            lat = lat + 1;
         end
         check(done, 24'h00_0001);
      end
   endtask
   // put a value into the secondary register between instructions
   task loadSec(input [23:0] v);
      begin
         @(negedge clk);
         secIn = v;
         secLoad = 1'b1;
         @(negedge clk);
         secLoad = 1'b0;
      end
   endtask
   // storage add of a half word, then the two sums with the secondary
   task secondaryOps;
      begin
         waitCyc = 4'h1;
         loadSec(24'h00_0100);
         cjasu_mem_model_i.mem[15'h0160] = 24'hAB_C020;
         run(`CJASU_OP_ADD, 3'h1, 15'h0150, 1'b1, 1'b0);
         check(accOut, 24'h00_001F);
         check(ok(20), 1'b1);
         run(`CJASU_OP_ADDQST, 3'h0, 15'h0160, 1'b1, 1'b0);
         check(accOut, 24'h00_011F);
         check(cjasu_mem_model_i.mem[15'h0170], 24'h00_011F);
         check(secOut, 24'h00_0100);
         check(ok(36), 1'b1);
         cjasu_mem_model_i.mem[15'h0180] = 24'h12_3456;
         run(`CJASU_OP_STPQWB, 3'h2, 15'h0170, 1'b1, 1'b0);
         check(accOut, 24'h00_0223);
         check(cjasu_mem_model_i.mem[15'h0180], 24'h22_3456);
         check(secOut, 24'h00_0100);
         check(ok(48), 1'b1);
      end
   endtask
   task loadAndAddImm;
      begin
         cjasu_mem_model_i.mem[15'h0110] = 24'h00_0005;
         run(`CJASU_OP_LDSUMQ, 3'h0, 15'h0100, 1'b1, 1'b0);
         check(accOut, 24'h00_0005);
         check(secOut, 24'h00_0000);
         check(ok(28), 1'b1);
         run(`CJASU_OP_ADDIMM, 3'h7, 15'h0003, 1'b1, 1'b0);
         check(accOut, 24'h00_0018);
         check(ok(12), 1'b1);
      end
   endtask
   // slow storage; negative result, then a sum needing end-around carry
   task subAndAddBack;
      begin
         waitCyc = 4'h3;
         cjasu_mem_model_i.mem[15'h0120] = 24'h00_0020;
         run(`CJASU_OP_SUB, 3'h0, 15'h0110, 1'b1, 1'b0);
         check(accOut, 24'hFF_FFF7);
         check(ok(20), 1'b1);
         cjasu_mem_model_i.mem[15'h0130] = 24'h00_0010;
         run(`CJASU_OP_ADDWB, 3'h0, 15'h0120, 1'b1, 1'b0);
         check(accOut, 24'h00_0008);
         check(cjasu_mem_model_i.mem[15'h0130], 24'h00_0008);
         check(ok(40), 1'b1);
      end
   endtask
   task incrAndSubtract;
      begin
         cjasu_mem_model_i.mem[15'h0140] = 24'hFF_FFFF;
         run(`CJASU_OP_INCST, 3'h0, 15'h0130, 1'b1, 1'b0);
         check(accOut, 24'h00_0001);
         check(cjasu_mem_model_i.mem[15'h0140], 24'h00_0001);
         check(ok(40), 1'b1);
         indexSel = 3'h0;
         run(`CJASU_OP_SUBIMM, 3'h5, 15'h0001, 1'b0, 1'b0);
         check(accOut, 24'hFF_FFFF);
         check(ok(32), 1'b1);
         cjasu_mem_model_i.mem[15'h0150] = 24'h00_0001;
         run(`CJASU_OP_SUBWB, 3'h0, 15'h0150, 1'b1, 1'b0);
         check(accOut, 24'hFF_FFFE);
         check(cjasu_mem_model_i.mem[15'h0150], 24'hFF_FFFE);
         indexSel = 3'h2;
      end
   endtask
   // positive secondary: odd m falls through, even m jumps; then odd m on negative
   task jumpCases;
      begin
         waitCyc = 4'h0;
         loadSec(24'h12_3456);
         cjasu_mem_model_i.mem[15'h0310] = 24'h55_5555;
         cjasu_mem_model_i.mem[15'h0000] = 24'h55_5555;
         run(`CJASU_OP_QJUMP, 3'h1, 15'h0300, 1'b1, 1'b0);
         check(jumpTaken, 1'b0);
         check(nextAddr, 15'h0201);
         check(repeatEnd, 1'b0);
         check(ok(20), 1'b1);
         check(secOut, 24'h24_68AC);
         run(`CJASU_OP_QJUMP, 3'h0, 15'h0300, 1'b1, 1'b0);
         check(jumpTaken, 1'b1);
         check(nextAddr, 15'h0310);
         check(repeatEnd, 1'b1);
         check(ok(40), 1'b1);
         run(`CJASU_OP_QJUMP, 3'h6, 15'h0300, 1'b0, 1'b0);
         check(cjasu_mem_model_i.mem[15'h0310][14:0], 15'h0201);
         check(nextAddr, 15'h0311);
         check(ok(56), 1'b1);
         check(secOut, 24'h48_D158);
         loadSec(24'h91_A2B3);
         run(`CJASU_OP_QJUMP, 3'h3, 15'h0300, 1'b0, 1'b1);
         check(jumpTaken, 1'b1);
         check(cjasu_mem_model_i.mem[15'h0000][14:0], 15'h0201);
         check(nextAddr, 15'h0001);
         check(ok(56), 1'b1);
         check(secOut, 24'h91_A2B3);
      end
   endtask
   // cut a hung run short
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 99000) begin
         errorCnt = errorCnt + 1;
         endOfTest;
      end
   end
   // reset for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(negedge clk);
      reset = 1'b0;
      loadAndAddImm;
      subAndAddBack;
      incrAndSubtract;
      secondaryOps;
      jumpCases;
      endOfTest;
   end
endmodule // test_cjasu_unit
